// [hw/fdp_pkg.sv]
package fdp_pkg;

	// Bus and flash widths
	localparam int FDP_WB_AW    = 8;
	localparam int FDP_FLASH_AW = 16;
	localparam int FDP_DW       = 32;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] FDP_CTRL_OFS   = 8'h00;
	localparam logic [7:0] FDP_PROT_OFS   = 8'h04;
	localparam logic [7:0] FDP_ROW_WP_OFS = 8'h08;
	localparam logic [7:0] FDP_ROW_RP_OFS = 8'h0C;
	localparam logic [7:0] FDP_STAT_OFS   = 8'h10;

	// Field positions
	localparam int FDP_CTRL_DBGEN_BIT = 0;
	localparam int FDP_STAT_ERASE_BIT = 0;
	localparam int FDP_STAT_BUSY_BIT  = 1;
	localparam int FDP_STAT_DENY_BIT  = 2;
	localparam int FDP_STAT_LOAD_BIT  = 3;

	// Reset values
	localparam logic FDP_DBGEN_RST = 1'b1;

	// Row protection geometry
	localparam int FDP_ROWS    = 16;
	localparam int FDP_ROW_LSB = 7;

	// Flash timing: zero wait states up to this clock rate
	localparam int FDP_CLK_KHZ = 100000;
	localparam int FDP_ZWS_KHZ = 24000;
	localparam int FDP_READ_WS =
		(FDP_CLK_KHZ + FDP_ZWS_KHZ - 1) / FDP_ZWS_KHZ - 1;

	// Chip-level protection state
	typedef enum logic [2:0] {
		FDP_OPEN = 3'h1,
		FDP_PROT = 3'h2,
		FDP_KILL = 3'h4
	} fdp_prot_t;

	// Flash operations
	typedef enum logic [1:0] {
		FDP_OP_READ      = 2'h0,
		FDP_OP_WRITE     = 2'h1,
		FDP_OP_ERASE_ROW = 2'h2,
		FDP_OP_ERASE_ALL = 2'h3
	} fdp_op_t;

	// Access sequencer states
	typedef enum logic [3:0] {
		FDP_F_LOAD = 4'h1,
		FDP_F_IDLE = 4'h2,
		FDP_F_BUSY = 4'h4,
		FDP_F_RESP = 4'h8
	} fdp_fsm_t;

	typedef struct packed {
		logic                    valid;
		fdp_op_t                 op;
		logic [FDP_FLASH_AW-1:0] addr;
		logic [FDP_DW-1:0]       wdata;
	} fdp_req_t;

	typedef struct packed {
		logic              ack;
		logic              err;
		logic [FDP_DW-1:0] rdata;
	} fdp_rsp_t;

	typedef struct packed {
		logic                 cyc;
		logic                 stb;
		logic                 we;
		logic [3:0]           sel;
		logic [FDP_WB_AW-1:0] adr;
		logic [FDP_DW-1:0]    dat;
	} fdp_wb_req_t;

	typedef struct packed {
		logic              ack;
		logic [FDP_DW-1:0] dat;
	} fdp_wb_rsp_t;

endpackage

// [hw/fdp_gate.sv]
`timescale 1ns/1ps
// Permission check for one flash request
module fdp_gate
	import fdp_pkg::*;
#(
	parameter int ROWS    = FDP_ROWS,
	parameter int ROW_LSB = FDP_ROW_LSB
) (
	input  wire fdp_prot_t        prot_i,
	input  wire logic             dbg_en_i,
	input  wire logic             from_dbg_i,
	input  wire fdp_req_t         req_i,
	input  wire logic [ROWS-1:0]  row_wp_i,
	input  wire logic [ROWS-1:0]  row_rp_i,
	output      logic             allow_o
);

	localparam int RW = (ROWS > 1) ? $clog2(ROWS) : 1;

	// Row index taken from the flash address
	function automatic logic [RW-1:0] row_of(
		input logic [FDP_FLASH_AW-1:0] a);
		row_of = a[ROW_LSB +: RW];
	endfunction

	logic [RW-1:0] row;
	logic          chip_ok;
	logic          row_ok;

	assign row = row_of(req_i.addr);

	// Probe passes only in open state with debug on
	always_comb begin
		chip_ok = 1'b1;
		if (from_dbg_i) begin
			chip_ok = dbg_en_i && (prot_i == FDP_OPEN); // RQ3 RQ5 RQ7 RQ8
		end
	end

	// Row bits apply to both sources; mass erase clears them anyway
	always_comb begin
		unique case (req_i.op)
			FDP_OP_READ:      row_ok = !row_rp_i[row]; // RQ9
			FDP_OP_WRITE:     row_ok = !row_wp_i[row]; // RQ9
			FDP_OP_ERASE_ROW: row_ok = !row_wp_i[row]; // RQ9
			FDP_OP_ERASE_ALL: row_ok = 1'b1;
		endcase
	end

	// Internal callers ignore chip state
	assign allow_o = chip_ok && row_ok; // RQ10

endmodule

// [hw/fdp_ctrl.sv]
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Overview of operation
// RQ1: Debug is enabled by every reset and only firmware can turn it off.
// RQ2: Debug comes back only after a full erase with protection cleared.
// RQ3: Maximum security blocks all external program, debug and test paths.
// RQ4: The protection state is open by default after shipping.
// RQ5: Open may go to protected, which refuses every probe access.
// RQ6: Protected returns to open only after a complete flash erase.
// RQ7: Open may go to kill, which blocks debug and can never be left.
// RQ8: In kill an erase from outside the chip is rejected.
// RQ9: Per-row bits block writes to a row and optionally its reads.
// RQ10: Internal flash calls are served whatever the protection state.
// RQ11: Flash reads have no wait states at a 24 MHz clock.
// RQ12: Any protection change other than the three legal ones is ignored.
// RQ13: Protection state and row bits live in nonvolatile storage.
module fdp_ctrl
	import fdp_pkg::*;
#(
	parameter int ROWS    = FDP_ROWS,
	parameter int ROW_LSB = FDP_ROW_LSB,
	parameter int READ_WS = FDP_READ_WS
) (
	input  wire  logic            clk_i,
	input  wire  logic            rst_i,
	input  wire  fdp_wb_req_t     wb_req_i,
	output       fdp_wb_rsp_t     wb_rsp_o,
	input  wire  fdp_req_t        sys_req_i,
	output       fdp_rsp_t        sys_rsp_o,
	input  wire  fdp_req_t        dbg_req_i,
	output       fdp_rsp_t        dbg_rsp_o,
	output       fdp_req_t        fl_req_o,
	input  wire  logic [31:0]     fl_rdata_i,
	input  wire  logic            fl_done_i,
	input  wire  logic            nv_valid_i,
	input  wire  logic [2:0]      nv_prot_i,
	input  wire  logic [ROWS-1:0] nv_row_wp_i,
	input  wire  logic [ROWS-1:0] nv_row_rp_i,
	output       logic            nv_wr_o,
	output       logic [2:0]      nv_prot_o,
	output       logic [ROWS-1:0] nv_row_wp_o,
	output       logic [ROWS-1:0] nv_row_rp_o,
	output       logic [2:0]      prot_state_o,
	output       logic            dbg_en_o,
	output       logic            test_if_en_o
);

	localparam int WS_W = (READ_WS > 0) ? $clog2(READ_WS + 1) : 1;
	localparam logic [WS_W-1:0] WS_LAST = WS_W'(READ_WS);
	localparam int RD_LAT = READ_WS + 1;

	typedef struct packed {
		fdp_fsm_t                fsm;
		fdp_prot_t               prot;
		logic                    dbg_en;
		logic [ROWS-1:0]         row_wp;
		logic [ROWS-1:0]         row_rp;
		logic                    erased;
		logic                    deny;
		logic                    src_dbg;
		fdp_op_t                 op;
		logic [FDP_FLASH_AW-1:0] addr;
		logic [31:0]             wdata;
		logic [WS_W-1:0]         wcnt;
		logic                    rsp_err;
		logic [31:0]             rdata;
		logic                    wb_ack;
		logic [31:0]             wb_dat;
		logic                    nv_wr;
	} fdp_st_t;

	fdp_st_t  s_q;
	fdp_st_t  s_d;
	fdp_req_t pick;
	logic     allow;
	logic     loaded;
	logic     wb_hit;
	logic     wb_wr;
	logic     deny_set;
	logic [2:0] req_prot;

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		lane_merge = (old & ~m) | (dat & m);
	endfunction

	// Register read decode; unmapped words read as zero
	function automatic logic [31:0] rd_word(input logic [7:0] a,
		input fdp_st_t s);
		rd_word = 32'h0000_0000;
		unique case (a)
			FDP_CTRL_OFS:   rd_word[FDP_CTRL_DBGEN_BIT] = s.dbg_en;
			FDP_PROT_OFS:   rd_word[2:0] = s.prot;
			FDP_ROW_WP_OFS: rd_word = 32'(s.row_wp);
			FDP_ROW_RP_OFS: rd_word = 32'(s.row_rp);
			FDP_STAT_OFS: begin
				rd_word[FDP_STAT_ERASE_BIT] = s.erased;
				rd_word[FDP_STAT_BUSY_BIT]  = (s.fsm == FDP_F_BUSY);
				rd_word[FDP_STAT_DENY_BIT]  = s.deny;
				rd_word[FDP_STAT_LOAD_BIT]  = (s.fsm != FDP_F_LOAD);
			end
			default:        rd_word = 32'h0000_0000;
		endcase
	endfunction

	// Internal calls win arbitration over the probe
	assign pick   = sys_req_i.valid ? sys_req_i : dbg_req_i;
	assign loaded = (s_q.fsm != FDP_F_LOAD);
	assign wb_hit = wb_req_i.cyc && wb_req_i.stb;
	// Writes land on the edge where the master sees ack
	assign wb_wr    = wb_hit && wb_req_i.we && s_q.wb_ack;
	assign req_prot = wb_req_i.dat[2:0];

	fdp_gate #(
		.ROWS    (ROWS),
		.ROW_LSB (ROW_LSB)
	) u_gate (
		.prot_i     (s_q.prot),
		.dbg_en_i   (s_q.dbg_en),
		.from_dbg_i (!sys_req_i.valid),
		.req_i      (pick),
		.row_wp_i   (s_q.row_wp),
		.row_rp_i   (s_q.row_rp),
		.allow_o    (allow)
	);

	// Next-state logic for registers, protection and the access sequencer
	always_comb begin
		s_d      = s_q;
		s_d.nv_wr = 1'b0;
		deny_set = 1'b0;
		// Registered ack gives one wait cycle and drops after one cycle
		s_d.wb_ack = wb_hit && !s_q.wb_ack;
		if (wb_hit && !s_q.wb_ack) begin
			s_d.wb_dat = rd_word(wb_req_i.adr, s_q);
		end
		// Deny flag clears on write-one; a new denial below still wins
		if (wb_wr && wb_req_i.adr == FDP_STAT_OFS && wb_req_i.sel[0] &&
			wb_req_i.dat[FDP_STAT_DENY_BIT]) begin
			s_d.deny = 1'b0;
		end
		// Firmware may drop debug any time; raising needs a clean part
		if (wb_wr && wb_req_i.adr == FDP_CTRL_OFS && wb_req_i.sel[0]) begin
			if (!wb_req_i.dat[FDP_CTRL_DBGEN_BIT]) begin
				s_d.dbg_en = 1'b0; // RQ1
			end else if (!s_q.dbg_en) begin
				if (s_q.erased && s_q.prot == FDP_OPEN) begin
					s_d.dbg_en = 1'b1; // RQ2
				end else begin
					deny_set = 1'b1; // RQ2
				end
			end
		end
		// Protection changes: only the three legal steps are taken
		if (wb_wr && wb_req_i.adr == FDP_PROT_OFS && wb_req_i.sel[0] &&
			loaded) begin
			if (s_q.prot == FDP_OPEN && req_prot == FDP_PROT) begin
				s_d.prot  = FDP_PROT; // RQ5
				s_d.nv_wr = 1'b1; // RQ13
			end else if (s_q.prot == FDP_OPEN && req_prot == FDP_KILL) begin
				s_d.prot  = FDP_KILL; // RQ7
				s_d.nv_wr = 1'b1; // RQ13
			end else if (s_q.prot == FDP_PROT && req_prot == FDP_OPEN &&
				s_q.erased) begin
				s_d.prot  = FDP_OPEN; // RQ6
				s_d.nv_wr = 1'b1; // RQ13
			end else begin
				deny_set = 1'b1; // RQ12
			end
		end
		// Row-bit register writes are refused outside the open state
		if (wb_wr && loaded && (wb_req_i.adr == FDP_ROW_WP_OFS ||
			wb_req_i.adr == FDP_ROW_RP_OFS)) begin
			if (s_q.prot == FDP_OPEN) begin
				if (wb_req_i.adr == FDP_ROW_WP_OFS) begin
					s_d.row_wp = ROWS'(lane_merge(32'(s_q.row_wp),
						wb_req_i.dat, wb_req_i.sel)); // RQ9
				end else begin
					s_d.row_rp = ROWS'(lane_merge(32'(s_q.row_rp),
						wb_req_i.dat, wb_req_i.sel)); // RQ9
				end
				s_d.nv_wr = 1'b1; // RQ13
			end else begin
				deny_set = 1'b1;
			end
		end
		// Access sequencer
		unique case (s_q.fsm)
			FDP_F_LOAD: begin
				// Unknown stored codes fall back to the safest state
				if (nv_valid_i) begin
					unique case (nv_prot_i)
						FDP_OPEN: s_d.prot = FDP_OPEN; // RQ13
						FDP_PROT: s_d.prot = FDP_PROT; // RQ13
						default:  s_d.prot = FDP_KILL;
					endcase
					s_d.row_wp = nv_row_wp_i; // RQ13
					s_d.row_rp = nv_row_rp_i; // RQ13
					s_d.fsm    = FDP_F_IDLE;
				end
			end
			FDP_F_IDLE: begin
				if (pick.valid) begin
					s_d.src_dbg = !sys_req_i.valid;
					s_d.op      = pick.op;
					s_d.addr    = pick.addr;
					s_d.wdata   = pick.wdata;
					s_d.wcnt    = '0;
					s_d.rdata   = 32'h0000_0000;
					if (allow) begin
						s_d.rsp_err = 1'b0; // RQ10
						s_d.fsm     = FDP_F_BUSY;
					end else begin
						s_d.rsp_err = 1'b1; // RQ5 RQ8
						deny_set    = 1'b1;
						s_d.fsm     = FDP_F_RESP;
					end
				end
			end
			FDP_F_BUSY: begin
				if (s_q.op == FDP_OP_READ) begin
					// Read data is sampled after the fixed wait count
					if (s_q.wcnt == WS_LAST) begin
						s_d.rdata = fl_rdata_i; // RQ11
						s_d.fsm   = FDP_F_RESP;
					end else begin
						s_d.wcnt = s_q.wcnt + WS_W'(1);
					end
				end else if (fl_done_i) begin
					s_d.fsm = FDP_F_RESP;
					if (s_q.op == FDP_OP_ERASE_ALL) begin
						// Mass erase also clears row protection
						s_d.erased = 1'b1; // RQ2 RQ6
						s_d.row_wp = '0;
						s_d.row_rp = '0;
						s_d.nv_wr  = 1'b1; // RQ13
					end else begin
						s_d.erased = 1'b0;
					end
				end
			end
			FDP_F_RESP: begin
				s_d.fsm = FDP_F_IDLE;
			end
			default: begin
				s_d.fsm = FDP_F_LOAD;
			end
		endcase
		if (deny_set) begin
			s_d.deny = 1'b1;
		end
	end

	// State register; reset opens the part with debug on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q        <= '0;
			s_q.fsm    <= FDP_F_LOAD;
			s_q.prot   <= FDP_OPEN; // RQ4
			s_q.dbg_en <= FDP_DBGEN_RST; // RQ1
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state
	assign wb_rsp_o.ack    = s_q.wb_ack;
	assign wb_rsp_o.dat    = s_q.wb_dat;
	assign sys_rsp_o.ack   = (s_q.fsm == FDP_F_RESP) && !s_q.src_dbg;
	assign sys_rsp_o.err   = s_q.rsp_err;
	assign sys_rsp_o.rdata = s_q.rdata;
	assign dbg_rsp_o.ack   = (s_q.fsm == FDP_F_RESP) && s_q.src_dbg;
	assign dbg_rsp_o.err   = s_q.rsp_err;
	assign dbg_rsp_o.rdata = s_q.rdata;
	assign fl_req_o.valid  = (s_q.fsm == FDP_F_BUSY);
	assign fl_req_o.op     = s_q.op;
	assign fl_req_o.addr   = s_q.addr;
	assign fl_req_o.wdata  = s_q.wdata;
	assign nv_wr_o         = s_q.nv_wr;
	assign nv_prot_o       = s_q.prot;
	assign nv_row_wp_o     = s_q.row_wp;
	assign nv_row_rp_o     = s_q.row_rp;
	assign prot_state_o    = s_q.prot;
	// Debug logic is off until the stored state is known
	assign dbg_en_o = s_q.dbg_en && loaded && s_q.prot == FDP_OPEN;
	// Test paths die for good in the kill state
	assign test_if_en_o = loaded && s_q.prot != FDP_KILL; // RQ3

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	rst_defaults_a: assert property ( // RQ1
		$past(rst_i) |-> s_q.prot == FDP_OPEN && s_q.dbg_en &&
			s_q.fsm == FDP_F_LOAD)
		else $error("reset did not open part with debug on");

	dbg_reenable_a: assert property ( // RQ2
		!$past(rst_i) && $rose(s_q.dbg_en) |->
			$past(s_q.erased) && $past(s_q.prot) == FDP_OPEN)
		else $error("debug re-enabled without full erase");

	kill_iface_a: assert property ( // RQ3
		s_q.prot == FDP_KILL |-> !test_if_en_o && !dbg_en_o)
		else $error("interface open in kill state");

	prot_probe_a: assert property ( // RQ5
		s_q.fsm == FDP_F_IDLE && !sys_req_i.valid && dbg_req_i.valid &&
		s_q.prot != FDP_OPEN |=> s_q.fsm == FDP_F_RESP && s_q.rsp_err &&
			dbg_rsp_o.ack && dbg_rsp_o.err)
		else $error("probe access not refused");

	open_erase_a: assert property ( // RQ6
		s_q.prot == FDP_PROT ##1 s_q.prot == FDP_OPEN |->
			$past(s_q.erased))
		else $error("left protected without full erase");

	kill_stays_a: assert property ( // RQ7
		s_q.prot == FDP_KILL && loaded |=> s_q.prot == FDP_KILL [*4])
		else $error("kill state was left");

	kill_erase_a: assert property ( // RQ8
		s_q.fsm == FDP_F_IDLE && !sys_req_i.valid && dbg_req_i.valid &&
		dbg_req_i.op == FDP_OP_ERASE_ALL && s_q.prot == FDP_KILL |=>
			!fl_req_o.valid)
		else $error("external erase ran in kill state");

	row_block_a: assert property ( // RQ9
		s_q.fsm == FDP_F_IDLE && pick.valid &&
		pick.op == FDP_OP_WRITE &&
		s_q.row_wp[pick.addr[ROW_LSB +: $clog2(ROWS)]] |=>
			s_q.rsp_err && s_q.deny)
		else $error("write to protected row not refused");

	sys_pass_a: assert property ( // RQ10
		s_q.fsm == FDP_F_IDLE && sys_req_i.valid &&
		sys_req_i.op == FDP_OP_ERASE_ALL |=> fl_req_o.valid)
		else $error("internal erase refused");

	read_lat_a: assert property ( // RQ11
		$rose(fl_req_o.valid) && fl_req_o.op == FDP_OP_READ |->
			##RD_LAT s_q.fsm == FDP_F_RESP && !s_q.rsp_err)
		else $error("read latency wrong");

	legal_step_a: assert property ( // RQ12
		loaded && $past(loaded) && $changed(s_q.prot) |->
			($past(s_q.prot) == FDP_OPEN && s_q.prot != FDP_OPEN) ||
			($past(s_q.prot) == FDP_PROT && s_q.prot == FDP_OPEN))
		else $error("illegal protection step");

	nv_store_a: assert property ( // RQ13
		loaded && $past(loaded) && $changed(s_q.prot) |-> nv_wr_o)
		else $error("protection change not stored");

	kill_entry_c:  cover property (
		s_q.prot == FDP_OPEN ##1 s_q.prot == FDP_KILL);
	prot_exit_c:   cover property (
		s_q.prot == FDP_PROT ##1 s_q.prot == FDP_OPEN);
	probe_read_c:  cover property (
		dbg_rsp_o.ack && !dbg_rsp_o.err);
	mass_erase_c:  cover property (
		fl_req_o.valid && fl_req_o.op == FDP_OP_ERASE_ALL && fl_done_i);

endmodule

// [verification/fdp_probe.sv]
`timescale 1ns/1ps
// External debug probe: one flash request for each go pulse
module fdp_probe
	import fdp_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire fdp_req_t   cmd_i,
	input  wire logic [3:0] lag_i,
	input  wire fdp_rsp_t   dbg_rsp_i,
	output      fdp_req_t   dbg_req_o,
	output      logic       done_o,
	output      fdp_rsp_t   got_o
);
	logic [3:0] wait_q = 4'h0;
	logic       busy_q = 1'b0;

	initial begin
		dbg_req_o = '0;
		done_o = 1'b0;
		got_o = '0;
	end

	// Request held until the ack edge; a slow lag tests late starts
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (go_i && !busy_q) begin
			busy_q <= 1'b1;
			wait_q <= lag_i;
		end else if (busy_q && !dbg_req_o.valid) begin
			if (wait_q == 4'h0) begin
				dbg_req_o <= '{1'b1, cmd_i.op, cmd_i.addr, cmd_i.wdata};
			end else begin
				wait_q <= wait_q - 4'h1;
			end
		end else if (dbg_req_o.valid && dbg_rsp_i.ack) begin
			got_o <= dbg_rsp_i;
			done_o <= 1'b1;
			busy_q <= 1'b0;
			// Released address and data carry inverted leftovers; the op keeps its stale value
			dbg_req_o <= '{1'b0, dbg_req_o.op, ~dbg_req_o.addr,
				~dbg_req_o.wdata};
		end
	end
endmodule

// [verification/fdp_ctrl_tb.sv]
`timescale 1ns/1ps
// Bench for the flash protection controller
module fdp_ctrl_tb;
	import fdp_pkg::*;
	typedef struct packed {
		logic        src;
		fdp_op_t     op;
		logic [15:0] a;
		logic        err;
	} fdp_case_t;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	fdp_wb_req_t         wb_req = '0;
	fdp_wb_rsp_t         wb_rsp;
	fdp_req_t            sys_req = '0;
	fdp_req_t            pcmd = '0;
	fdp_req_t            dbg_req;
	fdp_req_t            fl_req;
	fdp_rsp_t            sys_rsp;
	fdp_rsp_t            dbg_rsp;
	fdp_rsp_t            pgot;
	logic                pgo = 1'b0;
	logic                pdone;
	logic [3:0]          plag = 4'h0;
	logic                nv_wr;
	logic                nv_ok = 1'b0;
	logic [2:0]          nv_p = 3'h1;
	logic [2:0]          nv_po;
	logic [2:0]          prot;
	logic [FDP_ROWS-1:0] nv_w = '0;
	logic [FDP_ROWS-1:0] nv_r = '0;
	logic [FDP_ROWS-1:0] nv_wo;
	logic [FDP_ROWS-1:0] nv_ro;
	logic                dbg_en;
	logic                tst_en;
	logic                fl_done = 1'b0;
	logic [31:0]         fl_rd;
	logic [1:0]          fcnt = 2'h0;
	int                  fail_count = 0;
	int                  samples_checked = 0;
	fdp_case_t           cases [6] = '{
		'{1'b0, FDP_OP_READ, 16'h0010, 1'b0},
		'{1'b1, FDP_OP_READ, 16'h0104, 1'b0},
		'{1'b0, FDP_OP_WRITE, 16'h0200, 1'b0},
		'{1'b1, FDP_OP_WRITE, 16'h0300, 1'b0},
		'{1'b0, FDP_OP_ERASE_ROW, 16'h0080, 1'b0},
		'{1'b1, FDP_OP_ERASE_ROW, 16'h0400, 1'b0}};

	always #5 clk_i = ~clk_i;

	fdp_ctrl fdp_ctrl_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
		.sys_req_i(sys_req), .sys_rsp_o(sys_rsp), .dbg_req_i(dbg_req),
		.dbg_rsp_o(dbg_rsp), .fl_req_o(fl_req), .fl_rdata_i(fl_rd),
		.fl_done_i(fl_done), .nv_valid_i(nv_ok), .nv_prot_i(nv_p),
		.nv_row_wp_i(nv_w), .nv_row_rp_i(nv_r), .nv_wr_o(nv_wr),
		.nv_prot_o(nv_po), .nv_row_wp_o(nv_wo), .nv_row_rp_o(nv_ro),
		.prot_state_o(prot), .dbg_en_o(dbg_en), .test_if_en_o(tst_en));

	fdp_probe fdp_probe_i (
		.clk_i(clk_i), .go_i(pgo), .cmd_i(pcmd), .lag_i(plag),
		.dbg_rsp_i(dbg_rsp), .dbg_req_o(dbg_req), .done_o(pdone),
		.got_o(pgot));

	// Array data follows the address; inverted while nothing is selected
	assign fl_rd = fl_req.valid ? {16'hC3A5, fl_req.addr}
		: ~{16'hC3A5, fl_req.addr};

	// Writes and erases finish three cycles in, with one done pulse
	always @(posedge clk_i) begin
		fcnt <= (fl_req.valid && fl_req.op != FDP_OP_READ && !fl_done)
			? fcnt + 2'h1 : 2'h0;
		fl_done <= (fcnt == 2'h2);
	end

	// Nonvolatile image takes every store pulse and survives resets
	always @(posedge clk_i) begin
		if (nv_wr) begin
			nv_p <= nv_po;
			nv_w <= nv_wo;
			nv_r <= nv_ro;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic final_report;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Classic single cycle; only the watchdog ends a missing ack
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_req <= '{1'b1, 1'b1, we, 4'hF, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp.ack !== 1'b1);
		chk("bus latency", 2, n);
		q = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk_i);
	endtask

	// Flash request from internal code (src 0) or from the probe
	task automatic fop(input logic src, input fdp_op_t op,
		input logic [15:0] a, output fdp_rsp_t r, output int n);
		n = 0;
		if (!src) begin
			sys_req <= '{1'b1, op, a, {16'h5A00, ~a}};
			do begin
				@(posedge clk_i);
				n++;
			end while (sys_rsp.ack !== 1'b1);
			r = sys_rsp;
			sys_req <= '{1'b0, op, ~a, {16'hA5FF, a}};
		end else begin
			pcmd <= '{1'b1, op, a, {16'h5A00, ~a}};
			pgo <= 1'b1;
			@(posedge clk_i);
			pgo <= 1'b0;
			do begin
				@(posedge clk_i);
				n++;
			end while (pdone !== 1'b1);
			r = pgot;
		end
		chk("flash answer", 0, n > 98);
		@(posedge clk_i);
	endtask

	// Whole run is a few hundred cycles; this leaves a wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		final_report;
	end

	// Main sequence: reset, table of plain cases, then awkward cases
	initial begin
		fdp_rsp_t    r;
		logic [31:0] q;
		int          n;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("debug before load", 0, dbg_en);
		nv_ok <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("state", 1, prot);
		chk("debug enable", 1, dbg_en);
		chk("test enable", 1, tst_en);
		wb(0, FDP_PROT_OFS, 0, q);
		chk("prot reg", 1, q);
		wb(0, 8'h14, 0, q);
		chk("unmapped", 0, q);
		$display("test reset done");
		foreach (cases[i]) begin
			plag <= 4'(i);
			fop(cases[i].src, cases[i].op, cases[i].a, r, n);
			chk("err", cases[i].err, r.err);
			if (cases[i].op == FDP_OP_READ) begin
				chk("rdata", {16'hC3A5, cases[i].a}, r.rdata);
				if (!cases[i].src) chk("latency", FDP_READ_WS + 3, n);
			end
		end
		$display("test table done");
		wb(1, FDP_ROW_WP_OFS, 32'h0000_0020, q);
		fop(0, FDP_OP_WRITE, 16'h0280, r, n);
		chk("wp write", 1, r.err);
		fop(0, FDP_OP_ERASE_ROW, 16'h02FC, r, n);
		chk("wp erase", 1, r.err);
		fop(0, FDP_OP_WRITE, 16'h0300, r, n);
		chk("next row", 0, r.err);
		fop(0, FDP_OP_READ, 16'h0280, r, n);
		chk("wp read", 0, r.err);
		wb(1, FDP_ROW_RP_OFS, 32'h0000_0020, q);
		fop(0, FDP_OP_READ, 16'h0284, r, n);
		chk("rp read", 1, r.err);
		wb(0, FDP_STAT_OFS, 0, q);
		chk("deny", 1, q[FDP_STAT_DENY_BIT]);
		$display("test rows done");
		wb(1, FDP_CTRL_OFS, 0, q);
		chk("debug off", 0, dbg_en);
		fop(1, FDP_OP_READ, 16'h0010, r, n);
		chk("probe off", 1, r.err);
		wb(1, FDP_CTRL_OFS, 1, q);
		chk("debug stays off", 0, dbg_en);
		fop(0, FDP_OP_ERASE_ALL, 16'h0000, r, n);
		chk("erase all", 0, r.err);
		wb(0, FDP_STAT_OFS, 0, q);
		chk("erased", 1, q[FDP_STAT_ERASE_BIT]);
		wb(1, FDP_CTRL_OFS, 1, q);
		chk("debug back", 1, dbg_en);
		$display("test debug done");
		fop(0, FDP_OP_WRITE, 16'h0010, r, n);
		wb(1, FDP_PROT_OFS, 3, q);
		chk("bad code", 1, prot);
		wb(1, FDP_PROT_OFS, 2, q);
		chk("protected", 2, prot);
		chk("debug gated", 0, dbg_en);
		@(posedge clk_i);
		chk("stored state", 2, nv_p);
		fop(1, FDP_OP_READ, 16'h0010, r, n);
		chk("probe read", 1, r.err);
		fop(1, FDP_OP_ERASE_ALL, 16'h0000, r, n);
		chk("probe erase", 1, r.err);
		fop(0, FDP_OP_READ, 16'h0010, r, n);
		chk("internal read", 0, r.err);
		wb(1, FDP_PROT_OFS, 4, q);
		chk("prot to kill", 2, prot);
		wb(1, FDP_PROT_OFS, 1, q);
		chk("open unerased", 2, prot);
		fop(0, FDP_OP_ERASE_ALL, 16'h0000, r, n);
		chk("internal erase", 0, r.err);
		wb(1, FDP_PROT_OFS, 1, q);
		chk("open erased", 1, prot);
		$display("test protected done");
		wb(1, FDP_PROT_OFS, 4, q);
		chk("kill", 4, prot);
		chk("test off", 0, tst_en);
		chk("kill debug", 0, dbg_en);
		fop(1, FDP_OP_ERASE_ALL, 16'h0000, r, n);
		chk("kill erase", 1, r.err);
		wb(1, FDP_PROT_OFS, 1, q);
		chk("kill stays", 4, prot);
		fop(0, FDP_OP_WRITE, 16'h0500, r, n);
		chk("kill internal", 0, r.err);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("reload kill", 4, prot);
		chk("reload test", 0, tst_en);
		$display("test kill done");
		final_report;
	end
endmodule
